// file: pkg/cpuex_pkg.sv
/*
 * Constants for the instruction execute unit: register offsets, opcode
 * encodings, status flag positions, reset values and cycle counts.
 * Assumes a classic Wishbone master with 32-bit data and byte addresses.
 */
`default_nettype none
package cpuex_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_OPA = 8'h04;
	localparam logic [7:0] OFF_OPB = 8'h08;
	localparam logic [7:0] OFF_IOVAL = 8'h0C;
	localparam logic [7:0] OFF_SEL = 8'h10;
	localparam logic [7:0] OFF_OFFS = 8'h14;
	localparam logic [7:0] OFF_PC = 8'h18;
	localparam logic [7:0] OFF_ZPTR = 8'h1C;
	localparam logic [7:0] OFF_EXTENDED_INDIRECT_HIGH = 8'h20;
	localparam logic [7:0] OFF_STATUS_FLAGS_REGISTER = 8'h24;
	localparam logic [7:0] OFF_RESULT = 8'h28;
	localparam logic [7:0] OFF_PROD = 8'h2C;
	localparam logic [7:0] OFF_RET = 8'h30;
	localparam logic [7:0] OFF_CYC = 8'h34;
	localparam logic [4:0] OP_AND_IMMEDIATE = 5'h00;
	localparam logic [4:0] OP_ORI = 5'h01;
	localparam logic [4:0] OP_CLRB = 5'h02;
	localparam logic [4:0] OP_SETB = 5'h03;
	localparam logic [4:0] OP_TEST = 5'h04;
	localparam logic [4:0] OP_MUL = 5'h05;
	localparam logic [4:0] OP_MULTIPLY_SIGNED_OP = 5'h06;
	localparam logic [4:0] OP_MULTIPLY_SIGNED_UNSIGNED_OP = 5'h07;
	localparam logic [4:0] OP_FRACTIONAL_MULTIPLY_UNSIGNED_OP = 5'h08;
	localparam logic [4:0] OP_FRACTIONAL_MULTIPLY_SIGNED_OP = 5'h09;
	localparam logic [4:0] OP_FRACTIONAL_MULTIPLY_MIXED_OP = 5'h0A;
	localparam logic [4:0] OP_CMPI = 5'h0B;
	localparam logic [4:0] OP_COMPARE_SKIP_EQUAL_OP = 5'h0C;
	localparam logic [4:0] OP_RBITC = 5'h0D;
	localparam logic [4:0] OP_RBITS = 5'h0E;
	localparam logic [4:0] OP_IOBITC = 5'h0F;
	localparam logic [4:0] OP_IOBITS = 5'h10;
	localparam logic [4:0] OP_BRSET = 5'h11;
	localparam logic [4:0] OP_BRCLR = 5'h12;
	localparam logic [4:0] OP_INDIRECT_JUMP_OP = 5'h13;
	localparam logic [4:0] OP_EXTENDED_INDIRECT_JUMP_OP = 5'h14;
	localparam logic [4:0] OP_INDIRECT_CALL_OP = 5'h15;
	localparam logic [4:0] OP_EXTENDED_INDIRECT_CALL_OP = 5'h16;
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_H = 5;
	localparam int SEL_TWO_WORD = 3;
	localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_TWO = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR = 3'h4;
	typedef enum logic {CPUEX_IDLE, CPUEX_EXEC} cpuex_state_t;
endpackage : cpuex_pkg
`default_nettype wire

// file: design/cpuex_mult.sv
/*
 * Combinational 8x8 multiplier for the execute unit with signed, mixed
 * and fractional modes. Assumes the caller registers its outputs.
 */
`timescale 1ns/10ps
`default_nettype none
module cpuex_mult
(
	// Operands.
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	// Mode.
	input wire logic a_signed_i,
	input wire logic b_signed_i,
	input wire logic frac_i,
	// Results.
	output logic [15:0] prod_o,
	output logic carry_o
);
	logic signed [8:0] a_ext;
	logic signed [8:0] b_ext;
	logic signed [17:0] full;
	logic [15:0] raw;

	assign a_ext = $signed({a_signed_i & a_i[7], a_i});
	assign b_ext = $signed({b_signed_i & b_i[7], b_i});
	assign full = a_ext * b_ext;
	assign raw = full[15:0];
	// Carry is the top bit of the product before the fractional shift.
	assign carry_o = raw[15];
	assign prod_o = frac_i ? {raw[14:0], 1'b0} : raw;
endmodule : cpuex_mult
`default_nettype wire

// file: design/cpuex_core.sv
/*
 * Instruction execute unit: software loads operands, program counter,
 * pointer and status, then writes an opcode to launch one instruction.
 * Results, flags, the new counter and the cycle count are read back.
 * Assumes a classic Wishbone master on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module cpuex_core
	import cpuex_pkg::*;
#(
	parameter int PC_W = 22,
	parameter int EXTENDED_INDIRECT_HIGH_W = 1
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Status.
	output logic busy_o
);
	cpuex_state_t state_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] opa_q, opb_q, io_q, sel_q, offs_q, status_flags_register_q, res_q;
	logic [15:0] z_q, prod_q;
	logic [EXTENDED_INDIRECT_HIGH_W-1:0] extended_indirect_high_q;
	logic [PC_W-1:0] pc_q, ret_q;
	logic [2:0] cyc_q, cnt_q;
	logic req_w, wr_w, launch_w;
	logic [4:0] op_w;
	logic [31:0] rd_w;
	logic [15:0] mprod_w;
	logic mcarry_w;
	logic m_as_w, m_bs_w, m_fr_w;
	logic [7:0] ex_res, ex_status_flags_register;
	logic [15:0] ex_prod;
	logic [PC_W-1:0] ex_pc, ex_ret;
	logic [2:0] ex_cyc;
	logic skip_w, two_w, take_w;
	logic [2:0] bit_w;
	logic [8:0] diff_w;
	logic [PC_W-1:0] pc_seq, pc_skip, pc_br, pc_z, pc_ez;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[8*i +: 8] = val[8*i +: 8];
		end
		return r;
	endfunction : merge

	function automatic logic [7:0] logic_flags(input logic [7:0] s,
		input logic [7:0] r);
		logic [7:0] f;
		f = s;
		f[FL_Z] = (r == BYTE_RST);
		f[FL_N] = r[7];
		f[FL_V] = 1'b0;
		return f;
	endfunction : logic_flags

	assign req_w = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_w = req_w & wb_we_i;
	assign op_w = wb_dat_i[4:0];
	assign launch_w = wr_w & (wb_adr_i == OFF_CTRL) & (state_q == CPUEX_IDLE);

	assign m_as_w = (op_w == OP_MULTIPLY_SIGNED_OP) | (op_w == OP_MULTIPLY_SIGNED_UNSIGNED_OP) |
		(op_w == OP_FRACTIONAL_MULTIPLY_SIGNED_OP) | (op_w == OP_FRACTIONAL_MULTIPLY_MIXED_OP);
	assign m_bs_w = (op_w == OP_MULTIPLY_SIGNED_OP) | (op_w == OP_FRACTIONAL_MULTIPLY_SIGNED_OP);
	assign m_fr_w = (op_w == OP_FRACTIONAL_MULTIPLY_UNSIGNED_OP) | (op_w == OP_FRACTIONAL_MULTIPLY_SIGNED_OP) |
		(op_w == OP_FRACTIONAL_MULTIPLY_MIXED_OP);

	cpuex_mult u_mult
	(
		.a_i(opa_q),
		.b_i(opb_q),
		.a_signed_i(m_as_w),
		.b_signed_i(m_bs_w),
		.frac_i(m_fr_w),
		.prod_o(mprod_w),
		.carry_o(mcarry_w)
	);

	assign bit_w = sel_q[2:0];
	assign two_w = sel_q[SEL_TWO_WORD];
	assign diff_w = {1'b0, opa_q} - {1'b0, opb_q};
	assign pc_seq = pc_q + PC_W'(1);
	// A taken skip also passes over the second word of a long instruction.
	assign pc_skip = pc_q + (two_w ? PC_W'(3) : PC_W'(2));
	assign pc_br = pc_q + {{(PC_W-7){offs_q[6]}}, offs_q[6:0]} +
		PC_W'(1);
	assign pc_z = PC_W'(z_q);
	assign pc_ez = PC_W'({extended_indirect_high_q, z_q});
	assign take_w = status_flags_register_q[bit_w];

	always_comb
	begin
		ex_res = res_q;
		ex_status_flags_register = status_flags_register_q;
		ex_prod = prod_q;
		ex_pc = pc_seq;
		ex_ret = ret_q;
		ex_cyc = CYC_ONE;
		skip_w = 1'b0;
		case (op_w)
			OP_AND_IMMEDIATE:
			begin
				ex_res = opa_q & opb_q;
				ex_status_flags_register = logic_flags(status_flags_register_q, opa_q & opb_q);
			end
			OP_ORI:
			begin
				ex_res = opa_q | opb_q;
				ex_status_flags_register = logic_flags(status_flags_register_q, opa_q | opb_q);
			end
			OP_CLRB:
			begin
				ex_res = opa_q & (ALL_ONES - opb_q);
				ex_status_flags_register = logic_flags(status_flags_register_q, opa_q & (ALL_ONES - opb_q));
			end
			OP_SETB:
			begin
				ex_res = opa_q | opb_q;
				ex_status_flags_register = logic_flags(status_flags_register_q, opa_q | opb_q);
			end
			OP_TEST:
			begin
				ex_res = opa_q & opa_q;
				ex_status_flags_register = logic_flags(status_flags_register_q, opa_q);
			end
			OP_MUL, OP_MULTIPLY_SIGNED_OP, OP_MULTIPLY_SIGNED_UNSIGNED_OP, OP_FRACTIONAL_MULTIPLY_UNSIGNED_OP, OP_FRACTIONAL_MULTIPLY_SIGNED_OP, OP_FRACTIONAL_MULTIPLY_MIXED_OP:
			begin
				ex_prod = mprod_w;
				ex_status_flags_register[FL_Z] = (mprod_w == 16'h0000);
				ex_status_flags_register[FL_C] = mcarry_w;
				ex_cyc = CYC_TWO;
			end
			OP_CMPI:
			begin
				// The difference only drives flags; the result stays.
				ex_status_flags_register[FL_C] = diff_w[8];
				ex_status_flags_register[FL_Z] = (diff_w[7:0] == BYTE_RST);
				ex_status_flags_register[FL_N] = diff_w[7];
				ex_status_flags_register[FL_V] = (opa_q[7] & ~opb_q[7] & ~diff_w[7]) |
					(~opa_q[7] & opb_q[7] & diff_w[7]);
				ex_status_flags_register[FL_H] = (~opa_q[3] & opb_q[3]) |
					(opb_q[3] & diff_w[3]) | (diff_w[3] & ~opa_q[3]);
			end
			OP_COMPARE_SKIP_EQUAL_OP:
				skip_w = (opa_q == opb_q);
			OP_RBITC:
				skip_w = ~opa_q[bit_w];
			OP_RBITS:
				skip_w = opa_q[bit_w];
			OP_IOBITC:
				skip_w = ~io_q[bit_w];
			OP_IOBITS:
				skip_w = io_q[bit_w];
			OP_BRSET, OP_BRCLR:
			begin
				if (take_w == (op_w == OP_BRSET))
				begin
					ex_pc = pc_br;
					ex_cyc = CYC_TWO;
				end
			end
			OP_INDIRECT_JUMP_OP:
			begin
				ex_pc = pc_z;
				ex_cyc = CYC_TWO;
			end
			OP_EXTENDED_INDIRECT_JUMP_OP:
			begin
				ex_pc = pc_ez;
				ex_cyc = CYC_TWO;
			end
			OP_INDIRECT_CALL_OP:
			begin
				ex_ret = pc_seq;
				ex_pc = pc_z;
				ex_cyc = CYC_FOUR;
			end
			OP_EXTENDED_INDIRECT_CALL_OP:
			begin
				ex_ret = pc_seq;
				ex_pc = pc_ez;
				ex_cyc = CYC_FOUR;
			end
			default:
				ex_cyc = CYC_ONE;
		endcase
		if (skip_w)
		begin
			ex_pc = pc_skip;
			ex_cyc = two_w ? CYC_THREE : CYC_TWO;
		end
	end

	always_comb
	begin
		rd_w = 32'h0000_0000;
		case (wb_adr_i)
			OFF_CTRL: rd_w = {31'h0000_0000, state_q == CPUEX_EXEC};
			OFF_OPA: rd_w[7:0] = opa_q;
			OFF_OPB: rd_w[7:0] = opb_q;
			OFF_IOVAL: rd_w[7:0] = io_q;
			OFF_SEL: rd_w[7:0] = sel_q;
			OFF_OFFS: rd_w[7:0] = offs_q;
			OFF_PC: rd_w[PC_W-1:0] = pc_q;
			OFF_ZPTR: rd_w[15:0] = z_q;
			OFF_EXTENDED_INDIRECT_HIGH: rd_w[EXTENDED_INDIRECT_HIGH_W-1:0] = extended_indirect_high_q;
			OFF_STATUS_FLAGS_REGISTER: rd_w[7:0] = status_flags_register_q;
			OFF_RESULT: rd_w[7:0] = res_q;
			OFF_PROD: rd_w[15:0] = prod_q;
			OFF_RET: rd_w[PC_W-1:0] = ret_q;
			OFF_CYC: rd_w[2:0] = cyc_q;
			default: rd_w = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req_w;
			dat_q <= req_w ? rd_w : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= CPUEX_IDLE;
			cnt_q <= 3'h0;
		end
		else if (launch_w)
		begin
			state_q <= CPUEX_EXEC;
			cnt_q <= ex_cyc - CYC_ONE;
		end
		else if (state_q == CPUEX_EXEC)
		begin
			if (cnt_q == 3'h0)
				state_q <= CPUEX_IDLE;
			else
				cnt_q <= cnt_q - 3'h1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			res_q <= BYTE_RST;
			prod_q <= 16'h0000;
			ret_q <= '0;
			cyc_q <= 3'h0;
		end
		else if (launch_w)
		begin
			res_q <= ex_res;
			prod_q <= ex_prod;
			ret_q <= ex_ret;
			cyc_q <= ex_cyc;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			status_flags_register_q <= STATUS_FLAGS_REGISTER_RST;
			pc_q <= '0;
		end
		else if (launch_w)
		begin
			status_flags_register_q <= ex_status_flags_register;
			pc_q <= ex_pc;
		end
		else if (wr_w && wb_adr_i == OFF_STATUS_FLAGS_REGISTER)
			status_flags_register_q <= 8'(merge({24'h0, status_flags_register_q}, wb_dat_i, wb_sel_i));
		else if (wr_w && wb_adr_i == OFF_PC)
			pc_q <= PC_W'(merge(32'(pc_q), wb_dat_i, wb_sel_i));
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			opa_q <= BYTE_RST;
			opb_q <= BYTE_RST;
			io_q <= BYTE_RST;
			sel_q <= BYTE_RST;
			offs_q <= BYTE_RST;
			z_q <= 16'h0000;
			extended_indirect_high_q <= '0;
		end
		else if (wr_w && wb_sel_i[0])
		begin
			case (wb_adr_i)
				OFF_OPA: opa_q <= wb_dat_i[7:0];
				OFF_OPB: opb_q <= wb_dat_i[7:0];
				OFF_IOVAL: io_q <= wb_dat_i[7:0];
				OFF_SEL: sel_q <= wb_dat_i[7:0];
				OFF_OFFS: offs_q <= wb_dat_i[7:0];
				OFF_ZPTR: z_q <= 16'(merge({16'h0, z_q}, wb_dat_i, wb_sel_i));
				OFF_EXTENDED_INDIRECT_HIGH: extended_indirect_high_q <= wb_dat_i[EXTENDED_INDIRECT_HIGH_W-1:0];
				default: offs_q <= offs_q;
			endcase
		end
		else if (wr_w && wb_adr_i == OFF_ZPTR)
			z_q <= 16'(merge({16'h0, z_q}, wb_dat_i, wb_sel_i));
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign busy_o = (state_q == CPUEX_EXEC);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_go(logic [4:0] op);
		launch_w && op_w == op;
	endsequence

	chk_and_result: assert property (s_go(OP_AND_IMMEDIATE) |=> res_q ==
		($past(opa_q) & $past(opb_q)) && !status_flags_register_q[FL_V])
		else $error("and immediate result wrong");
	chk_or_result: assert property (s_go(OP_ORI) |=> res_q ==
		($past(opa_q) | $past(opb_q)) && status_flags_register_q[FL_N] == res_q[7])
		else $error("or immediate result wrong");
	chk_clear_bits: assert property (s_go(OP_CLRB) |=>
		res_q == ($past(opa_q) & ~$past(opb_q)))
		else $error("clear bits result wrong");
	chk_set_bits: assert property (s_go(OP_SETB) |=>
		(res_q & $past(opb_q)) == $past(opb_q))
		else $error("set bits left a bit clear");
	chk_test_flags: assert property (s_go(OP_TEST) |=> res_q ==
		$past(opa_q) && status_flags_register_q[FL_Z] == ($past(opa_q) == 8'h00))
		else $error("test flags wrong");
	chk_mul_timing: assert property (s_go(OP_MUL) |=>
		prod_q == ({8'h00, $past(opa_q)} * {8'h00, $past(opb_q)})
		##0 busy_o[*2] ##1 !busy_o)
		else $error("unsigned multiply wrong");
	chk_frac_shift: assert property (s_go(OP_FRACTIONAL_MULTIPLY_UNSIGNED_OP) |=>
		prod_q == (({8'h00, $past(opa_q)} * {8'h00, $past(opb_q)}) << 1))
		else $error("fractional product not shifted");
	chk_cmp_flags: assert property (s_go(OP_CMPI) |=>
		$stable(res_q) && status_flags_register_q[FL_C] == ($past(opa_q) < $past(opb_q)))
		else $error("compare immediate flags wrong");
	chk_compare_skip_equal_op_step: assert property (s_go(OP_COMPARE_SKIP_EQUAL_OP) ##0 opa_q != opb_q |=>
		pc_q == $past(pc_q) + PC_W'(1) && $stable(status_flags_register_q))
		else $error("compare skip stepped wrongly");
	chk_reg_skip: assert property (s_go(OP_RBITS) ##0 opa_q[bit_w]
		&& !two_w |=> pc_q == $past(pc_q) + PC_W'(2))
		else $error("register bit skip wrong");
	chk_io_skip: assert property (s_go(OP_IOBITC) ##0 !io_q[bit_w]
		&& two_w |=> pc_q == $past(pc_q) + PC_W'(3) && cyc_q == 3'h3)
		else $error("io bit skip wrong");
	chk_branch_take: assert property (s_go(OP_BRCLR) ##0 !take_w
		|=> pc_q == $past(pc_br) && cyc_q == 3'h2)
		else $error("flag branch target wrong");
	chk_ext_jump: assert property (s_go(OP_EXTENDED_INDIRECT_JUMP_OP) |=>
		pc_q == PC_W'({$past(extended_indirect_high_q), $past(z_q)}) ##2 !busy_o)
		else $error("extended jump wrong");
	chk_ext_call: assert property (s_go(OP_EXTENDED_INDIRECT_CALL_OP) |=>
		ret_q == $past(pc_q) + PC_W'(1) ##0 busy_o[*4] ##1 !busy_o)
		else $error("extended call wrong");
	chk_skip_long: assert property (s_go(OP_RBITC) ##0 !opa_q[bit_w]
		&& two_w |=> busy_o[*3] ##1 !busy_o)
		else $error("long skip cycle count wrong");
endmodule : cpuex_core
`default_nettype wire

// file: tb/cpu_instruction_execute_test.sv
/*
 * Self-checking bench for cpuex_core: random and corner operands for every
 * opcode, with results, flags, counter, cycles and busy time compared.
 * Assumes the core answers on classic Wishbone and runs on one clock.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_instruction_execute_test;
	import cpuex_pkg::*;
	localparam logic [31:0] PCM = 32'h003FFFFF;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel_w = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, busy;
	int err_total = 0, n_compared = 0, bcnt = 0, bd, tcnt = 0, seed_v;
	logic [7:0] a, b, io, sel, offs;
	logic [31:0] pc, z, ei, sr, r_res, r_prod, r_pc, r_status_flags_register, r_ret, r_cyc;
	logic [31:0] e, t;
	logic [4:0] op;
	logic c;
	int n;
	cpuex_core #(.PC_W(22), .EXTENDED_INDIRECT_HIGH_W(1)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel_w), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.busy_o(busy));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		if (busy === 1'b1)
			bcnt <= bcnt + 1;
		tcnt <= tcnt + 1;
		if (tcnt == 40000)
		begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wb(input logic w, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] rd);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		sel_w <= 4'hF;
		wdat <= d;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic run(input logic [4:0] o, input bit dbl);
		int st, k;
		logic [31:0] d;
		wb(1'b1, OFF_OPA, {24'h0, a}, d);
		wb(1'b1, OFF_OPB, {24'h0, b}, d);
		wb(1'b1, OFF_IOVAL, {24'h0, io}, d);
		wb(1'b1, OFF_SEL, {24'h0, sel}, d);
		wb(1'b1, OFF_OFFS, {24'h0, offs}, d);
		wb(1'b1, OFF_PC, pc, d);
		wb(1'b1, OFF_ZPTR, z, d);
		wb(1'b1, OFF_EXTENDED_INDIRECT_HIGH, ei, d);
		wb(1'b1, OFF_STATUS_FLAGS_REGISTER, sr, d);
		st = bcnt;
		wb(1'b1, OFF_CTRL, {27'h0, o}, d);
		if (dbl)
			wb(1'b1, OFF_CTRL, {27'h0, OP_AND_IMMEDIATE}, d);
		k = 0;
		while (busy !== 1'b0 && k < 20)
		begin
			@(posedge clk_i);
			k++;
		end
		bd = bcnt - st;
		wb(1'b0, OFF_RESULT, 32'h0, r_res);
		wb(1'b0, OFF_PROD, 32'h0, r_prod);
		wb(1'b0, OFF_PC, 32'h0, r_pc);
		wb(1'b0, OFF_STATUS_FLAGS_REGISTER, 32'h0, r_status_flags_register);
		wb(1'b0, OFF_RET, 32'h0, r_ret);
		wb(1'b0, OFF_CYC, 32'h0, r_cyc);
	endtask : run
	task automatic rnd();
		a = 8'($urandom);
		b = 8'($urandom);
		io = 8'($urandom);
		sel = 8'($urandom) & 8'h0F;
		offs = 8'($urandom) & 8'h7F;
		pc = $urandom & PCM;
		z = $urandom & 32'hFFFF;
		ei = $urandom & 32'h1;
		sr = $urandom & 32'hFF;
	endtask : rnd
	task automatic timing(input int cy);
		check(r_cyc, 32'(cy));
		check(32'(bd), 32'(cy));
	endtask : timing
	function automatic logic [31:0] lflag(input logic [31:0] s,
		input logic [7:0] r);
		return (s & 32'hF1) | {29'h0, r[7], r == 8'h00, 1'b0};
	endfunction : lflag
	function automatic logic [31:0] cflag(input logic [31:0] s,
		input logic [7:0] x, input logic [7:0] y);
		logic [7:0] d;
		logic h, v;
		d = x - y;
		h = (~x[3] & y[3]) | (y[3] & d[3]) | (d[3] & ~x[3]);
		v = (x[7] & ~y[7] & ~d[7]) | (~x[7] & y[7] & d[7]);
		return (s & 32'hD0) | {26'h0, h, 1'b0, v, d[7], d == 8'h00, x < y};
	endfunction : cflag
	function automatic logic [31:0] mexp(input logic [4:0] o,
		input logic [7:0] x, input logic [7:0] y);
		int xi, yi, p;
		logic [15:0] q;
		xi = (o == OP_MUL || o == OP_FRACTIONAL_MULTIPLY_UNSIGNED_OP) ? int'(x) : int'($signed(x));
		yi = (o == OP_MULTIPLY_SIGNED_OP || o == OP_FRACTIONAL_MULTIPLY_SIGNED_OP) ? int'($signed(y)) : int'(y);
		p = xi * yi;
		q = p[15:0];
		return {15'h0, q[15], (o >= OP_FRACTIONAL_MULTIPLY_UNSIGNED_OP) ? q << 1 : q};
	endfunction : mexp
	initial
	begin
		seed_v = $urandom(93);
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, OFF_STATUS_FLAGS_REGISTER, 32'h0, e);
		check(e, {24'h0, STATUS_FLAGS_REGISTER_RST});
		wb(1'b0, OFF_PC, 32'h0, e);
		check(e, 32'h0);
		wb(1'b1, 8'h3C, 32'hFFFFFFFF, e);
		wb(1'b0, 8'h3C, 32'h0, e);
		check(e, 32'h0);
		for (int i = 0; i < 160; i++)
		begin
			rnd();
			op = 5'(i % 5);
			if (i < 10)
				a = (i < 5) ? 8'h00 : 8'h80;
			case (op)
				OP_AND_IMMEDIATE: e = {24'h0, a & b};
				OP_ORI, OP_SETB: e = {24'h0, a | b};
				OP_CLRB: e = {24'h0, a & (ALL_ONES - b)};
				default: e = {24'h0, a};
			endcase
			if (i >= 40)
			begin
				op = (i < 100) ? 5'(OP_MUL + i % 6) : OP_CMPI;
				if (i < 52)
				begin
					a = (i < 46) ? 8'h80 : 8'h00;
					b = 8'h80;
				end
				if (i == 100)
					b = a;
			end
			run(op, 1'b0);
			check(r_pc, (pc + 1) & PCM);
			if (i < 40)
			begin
				check(r_res, e);
				check(r_status_flags_register, lflag(sr, e[7:0]));
				timing(1);
			end
			else if (i < 100)
			begin
				e = mexp(op, a, b);
				check(r_prod, {16'h0, e[15:0]});
				t = {30'h0, e[15:0] == 16'h0, e[16]};
				check(r_status_flags_register, (sr & 32'hFC) | t);
				timing(2);
			end
			else
			begin
				check(r_status_flags_register, cflag(sr, a, b));
				timing(1);
			end
		end
		for (int i = 0; i < 50; i++)
		begin
			rnd();
			op = 5'(OP_COMPARE_SKIP_EQUAL_OP + i % 5);
			if (op != OP_COMPARE_SKIP_EQUAL_OP || i % 2 == 1)
				b = a;
			if (op != OP_IOBITC && op != OP_IOBITS)
				io = ~a;
			else
				b = ~io;
			case (op)
				OP_COMPARE_SKIP_EQUAL_OP: c = (a == b);
				OP_RBITC: c = !a[sel[2:0]];
				OP_RBITS: c = a[sel[2:0]];
				OP_IOBITC: c = !io[sel[2:0]];
				default: c = io[sel[2:0]];
			endcase
			n = c ? (sel[3] ? 3 : 2) : 1;
			run(op, 1'b0);
			check(r_pc, (pc + n) & PCM);
			check(r_status_flags_register, sr);
			timing(n);
		end
		for (int i = 0; i < 24; i++)
		begin
			rnd();
			op = (i % 2 == 1) ? OP_BRCLR : OP_BRSET;
			if (i < 4)
				offs = (i < 2) ? 8'h40 : 8'h3F;
			c = sr[sel[2:0]] ^ (op == OP_BRCLR);
			t = c ? pc + {{25{offs[6]}}, offs[6:0]} + 1 : pc + 1;
			run(op, 1'b0);
			check(r_pc, t & PCM);
			check(r_status_flags_register, sr);
			timing(c ? 2 : 1);
		end
		for (int i = 0; i < 13; i++)
		begin
			rnd();
			op = (i == 12) ? OP_INDIRECT_CALL_OP : 5'(OP_INDIRECT_JUMP_OP + i % 4);
			t = (op == OP_EXTENDED_INDIRECT_JUMP_OP || op == OP_EXTENDED_INDIRECT_CALL_OP) ? {15'h0, ei[0], z[15:0]}
				: {16'h0, z[15:0]};
			run(op, i == 12);
			check(r_pc, t);
			check(r_status_flags_register, sr);
			timing((op >= OP_INDIRECT_CALL_OP) ? 4 : 2);
			if (op >= OP_INDIRECT_CALL_OP)
				check(r_ret, (pc + 1) & PCM);
		end
		rnd();
		run(5'h1F, 1'b0);
		check(r_pc, (pc + 1) & PCM);
		check(r_status_flags_register, sr);
		timing(1);
		test_done();
	end
endmodule : cpu_instruction_execute_test
`default_nettype wire
